// ===== inc/eeprom_pkg.sv
// Purpose: shared constants and state types for the two-wire eeprom read link
// Assumes: 100 MHz ref_clk on both ends
// Notes:   WR_CYCLES derives from WR_TIME_MS and CLK_MHZ; SCL_QTR is a fixed count of ref_clk cycles
package eeprom_pkg;
  localparam int ADDR_W   = 11;
  localparam int MEM_BYTES = 2048;
  localparam int PAGE_W   = 4;
  localparam logic [3:0] DEV_TYPE = 4'ha;
  localparam int BYTE_BITS = 8;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam int CLK_MHZ  = 100;
  localparam int WR_TIME_MS = 5;
  localparam int WR_CYCLES = WR_TIME_MS * CLK_MHZ * 1000;
  localparam int BUSY_W   = 20;
  localparam int SCL_QTR  = 16;
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 4;

  typedef enum logic [2:0] {
    DEV_IDLE  = 3'h0,
    DEV_ADDR  = 3'h1,
    DEV_WORD  = 3'h3,
    DEV_WDATA = 3'h2,
    DEV_RDATA = 3'h6,
    DEV_RACK  = 3'h7
  } dev_state_t;

  typedef enum logic [2:0] {
    CTL_IDLE  = 3'h0,
    CTL_START = 3'h1,
    CTL_SEND  = 3'h3,
    CTL_RECV  = 3'h2,
    CTL_STOP  = 3'h6
  } ctl_state_t;
endpackage

// ===== inc/two_wire_if.sv
// Purpose: two-wire link joining the bus controller and the eeprom target
// Assumes: sda is open drain with a pull-up; scl is driven only by the controller
// Notes:   the wired level of sda is resolved here from both enables
`timescale 1ns/10ps
`default_nettype none
interface two_wire_if;
  logic scl;
  logic ctl_sda_o;
  logic ctl_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic sda;

  // pulled high unless an enabled driver pulls low
  assign sda = ~((ctl_sda_oe & ~ctl_sda_o) | (dev_sda_oe & ~dev_sda_o));

  modport ctl (
    output scl,
    output ctl_sda_o,
    output ctl_sda_oe,
    input  sda
  );

  modport dev (
    input  scl,
    output dev_sda_o,
    output dev_sda_oe,
    input  sda
  );
endinterface
`default_nettype wire

// ===== rtl/eeprom_read_target.sv
// Purpose: eeprom target end of the two-wire link: addressing, write, reads
// Assumes: scl and sda are foreign to ref_clk and pass two flip-flops first
// Notes:   word-address counter has no reset so that it survives link resets
`timescale 1ns/10ps
`default_nettype none
module eeprom_read_target #(
  parameter int WR_CYCLES = eeprom_pkg::WR_CYCLES
) (
  input  wire logic       ref_clk,
  input  wire logic       reset,
  two_wire_if.dev         bus,
  output logic            busy,
  output logic [7:0]      rd_byte,
  output logic            rd_strobe
);

  localparam logic [eeprom_pkg::BUSY_W-1:0] BUSY_LOAD = WR_CYCLES[eeprom_pkg::BUSY_W-1:0];

  function automatic logic [eeprom_pkg::ADDR_W-1:0] read_inc(
    input logic [eeprom_pkg::ADDR_W-1:0] a);
    read_inc = a + 11'h001;
  endfunction

  function automatic logic [eeprom_pkg::ADDR_W-1:0] page_inc(
    input logic [eeprom_pkg::ADDR_W-1:0] a);
    page_inc = {a[eeprom_pkg::ADDR_W-1:eeprom_pkg::PAGE_W],
                a[eeprom_pkg::PAGE_W-1:0] + 4'h1};
  endfunction

  logic [7:0]                    mem [eeprom_pkg::MEM_BYTES];
  logic [eeprom_pkg::ADDR_W-1:0] addr_ff;
  logic [2:0]                    scl_s_ff;
  logic [2:0]                    sda_s_ff;
  eeprom_pkg::dev_state_t        state_ff;
  logic [3:0]                    bit_ff;
  logic [7:0]                    shift_ff;
  logic                          in_ack_ff;
  logic [2:0]                    page_ff;
  logic                          oe_ff;
  logic                          wrote_ff;
  logic [eeprom_pkg::BUSY_W-1:0] busy_cnt_ff;
  logic [7:0]                    rd_byte_ff;
  logic                          rd_strobe_ff;

  //////////////////////////////////////////////////////////////////////////
  // pin sampling and condition detection

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      scl_s_ff <= 3'h7;
      sda_s_ff <= 3'h7;
    end else begin
      scl_s_ff <= {scl_s_ff[1:0], bus.scl};
      sda_s_ff <= {sda_s_ff[1:0], bus.sda};
    end
  end

  wire scl_hi     = scl_s_ff[1];
  wire sda_now    = sda_s_ff[1];
  wire scl_rise   = scl_s_ff[1] & ~scl_s_ff[2];
  wire scl_fall   = ~scl_s_ff[1] & scl_s_ff[2];
  wire start_seen = scl_hi & scl_s_ff[2] & sda_s_ff[2] & ~sda_now;
  wire stop_seen  = scl_hi & scl_s_ff[2] & ~sda_s_ff[2] & sda_now;

  wire [7:0] mem_q     = mem[addr_ff];
  wire       is_busy   = busy_cnt_ff != '0;
  wire       rx_state  = (state_ff == eeprom_pkg::DEV_ADDR) |
                         (state_ff == eeprom_pkg::DEV_WORD) |
                         (state_ff == eeprom_pkg::DEV_WDATA);
  wire       byte_fall = scl_fall & ~in_ack_ff & rx_state & (bit_ff == eeprom_pkg::ACK_SLOT);
  wire       ack_fall  = scl_fall & in_ack_ff;
  wire       addr_hit  = (shift_ff[7:4] == eeprom_pkg::DEV_TYPE) & ~is_busy;
  wire       rd_done   = scl_fall & (state_ff == eeprom_pkg::DEV_RDATA) &
                         (bit_ff == eeprom_pkg::ACK_SLOT);
  wire       word_done = ack_fall & (state_ff == eeprom_pkg::DEV_WORD);
  wire       data_done = ack_fall & (state_ff == eeprom_pkg::DEV_WDATA);
  wire       rd_load   = (ack_fall & (state_ff == eeprom_pkg::DEV_ADDR) & shift_ff[0]) |
                         (scl_fall & (state_ff == eeprom_pkg::DEV_RACK));

  //////////////////////////////////////////////////////////////////////////
  // array and address counter: power-lifetime state, no reset

  // known fill so that reads never shift out undefined bits
  initial begin
    for (int i = 0; i < eeprom_pkg::MEM_BYTES; i++) begin
      mem[i] = 8'(i * 37 + 11);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (data_done) begin
      mem[addr_ff] <= shift_ff;
    end
    if (word_done) begin
      addr_ff <= {page_ff, shift_ff};
    end else if (data_done) begin
      addr_ff <= page_inc(addr_ff);
    end else if (rd_done) begin
      addr_ff <= read_inc(addr_ff);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // protocol sequencer

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_ff     <= eeprom_pkg::DEV_IDLE;
      bit_ff       <= 4'h0;
      shift_ff     <= 8'h00;
      in_ack_ff    <= 1'b0;
      page_ff      <= 3'h0;
      oe_ff        <= 1'b0;
      wrote_ff     <= 1'b0;
      busy_cnt_ff  <= '0;
      rd_byte_ff   <= 8'h00;
      rd_strobe_ff <= 1'b0;
    end else begin
      rd_strobe_ff <= 1'b0;
      if (is_busy) begin
        busy_cnt_ff <= busy_cnt_ff - 1'b1;
      end
      if (stop_seen) begin
        state_ff  <= eeprom_pkg::DEV_IDLE;
        oe_ff     <= 1'b0;
        in_ack_ff <= 1'b0;
        wrote_ff  <= 1'b0;
        if (wrote_ff) begin
          busy_cnt_ff <= BUSY_LOAD;
        end
      end else if (start_seen) begin
        state_ff  <= eeprom_pkg::DEV_ADDR;
        bit_ff    <= 4'h0;
        oe_ff     <= 1'b0;
        in_ack_ff <= 1'b0;
      end else if (scl_rise & rx_state & ~in_ack_ff & (bit_ff != eeprom_pkg::ACK_SLOT)) begin
        shift_ff <= {shift_ff[6:0], sda_now};
        bit_ff   <= bit_ff + 4'h1;
      end else if (scl_rise & (state_ff == eeprom_pkg::DEV_RACK) & sda_now) begin
        state_ff <= eeprom_pkg::DEV_IDLE;
      end else if (byte_fall) begin
        if ((state_ff != eeprom_pkg::DEV_ADDR) | addr_hit) begin
          oe_ff     <= 1'b1;
          in_ack_ff <= 1'b1;
          if (state_ff == eeprom_pkg::DEV_ADDR) begin
            page_ff <= shift_ff[3:1];
          end
        end else begin
          state_ff <= eeprom_pkg::DEV_IDLE;
        end
      end else if (rd_load) begin
        // first data bit goes out on the same fall that closes the ack slot
        state_ff     <= eeprom_pkg::DEV_RDATA;
        oe_ff        <= ~mem_q[7];
        shift_ff     <= {mem_q[6:0], 1'b0};
        bit_ff       <= 4'h1;
        in_ack_ff    <= 1'b0;
        rd_byte_ff   <= mem_q;
        rd_strobe_ff <= 1'b1;
      end else if (ack_fall) begin
        oe_ff     <= 1'b0;
        in_ack_ff <= 1'b0;
        bit_ff    <= 4'h0;
        if (state_ff == eeprom_pkg::DEV_ADDR) begin
          state_ff <= eeprom_pkg::DEV_WORD;
        end else begin
          state_ff <= eeprom_pkg::DEV_WDATA;
          wrote_ff <= state_ff == eeprom_pkg::DEV_WDATA;
        end
      end else if (scl_fall & (state_ff == eeprom_pkg::DEV_RDATA)) begin
        if (bit_ff == eeprom_pkg::ACK_SLOT) begin
          oe_ff    <= 1'b0;
          state_ff <= eeprom_pkg::DEV_RACK;
        end else begin
          oe_ff    <= ~shift_ff[7];
          shift_ff <= {shift_ff[6:0], 1'b0};
          bit_ff   <= bit_ff + 4'h1;
        end
      end
    end
  end

  assign bus.dev_sda_o  = 1'b0;
  assign bus.dev_sda_oe = oe_ff;
  assign busy           = is_busy;
  assign rd_byte        = rd_byte_ff;
  assign rd_strobe      = rd_strobe_ff;

endmodule
`default_nettype wire

// ===== rtl/eeprom_bus_controller.sv
// Purpose: bus controller end: current and random reads into a small fifo
// Assumes: this end owns scl, made from ref_clk by a quarter-period divider
// Notes:   a full fifo holds scl low before the ack slot, stalling the link
`timescale 1ns/10ps
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = eeprom_pkg::FIFO_WIDTH,
  parameter int DEPTH = eeprom_pkg::FIFO_DEPTH
) (
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  logic [WIDTH-1:0] buf_mem [DEPTH];
  logic [AW-1:0]    wr_ff;
  logic [AW-1:0]    rd_ff;
  logic [AW:0]      cnt_ff;

  wire push = in_valid & in_ready;
  wire pop  = out_valid & out_ready;

  assign in_ready  = cnt_ff != (AW+1)'(DEPTH);
  assign out_valid = cnt_ff != '0;
  assign out_data  = buf_mem[rd_ff];

  always_ff @(posedge ref_clk) begin
    if (push) begin
      buf_mem[wr_ff] <= in_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        wr_ff <= (wr_ff == LAST) ? '0 : wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff <= (rd_ff == LAST) ? '0 : rd_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////

module eeprom_bus_controller (
  input  wire logic                          ref_clk,
  input  wire logic                          reset,
  two_wire_if.ctl                            bus,
  input  wire logic                          cmd_valid,
  output logic                               cmd_ready,
  input  wire logic                          cmd_random,
  input  wire logic [eeprom_pkg::ADDR_W-1:0] cmd_addr,
  input  wire logic [7:0]                    cmd_len,
  output logic                               data_valid,
  input  wire logic                          data_ready,
  output logic [7:0]                         data_out,
  output logic                               done,
  output logic                               nack
);
  localparam logic [5:0] QTR_LAST = 6'(eeprom_pkg::SCL_QTR - 1);

  eeprom_pkg::ctl_state_t        state_ff;
  logic [5:0]                    qtr_ff;
  logic [1:0]                    ph_ff;
  logic [3:0]                    cnt_ff;
  logic [7:0]                    byte_ff;
  logic [7:0]                    rx_ff;
  logic [1:0]                    stage_ff;
  logic [7:0]                    rem_ff;
  logic [eeprom_pkg::ADDR_W-1:0] addr_ff;
  logic [1:0]                    sda_s_ff;
  logic                          scl_ff;
  logic                          low_ff;
  logic                          ackbit_ff;
  logic                          nack_ff;
  logic                          done_ff;
  logic                          f_ready;

  wire idle     = state_ff == eeprom_pkg::CTL_IDLE;
  wire tick     = qtr_ff == QTR_LAST;
  wire sda_in   = sda_s_ff[1];
  wire ack_cell = cnt_ff == eeprom_pkg::ACK_SLOT;
  wire in_recv  = state_ff == eeprom_pkg::CTL_RECV;
  wire in_send  = state_ff == eeprom_pkg::CTL_SEND;
  // a full fifo parks the link with scl low at the ack slot
  wire stall    = in_recv & ack_cell & (ph_ff == 2'h0) & ~f_ready;
  wire push     = tick & in_recv & ack_cell & (ph_ff == 2'h0) & f_ready;
  wire go       = tick & ~stall;
  wire drive_pt = go & (ph_ff == 2'h0);
  wire sample   = go & (ph_ff == 2'h2);
  wire cell_end = go & (ph_ff == 2'h3);
  wire more     = rem_ff != 8'h01;

  byte_fifo #(
    .WIDTH (eeprom_pkg::FIFO_WIDTH),
    .DEPTH (eeprom_pkg::FIFO_DEPTH)
  ) byte_fifo_i (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .in_valid  (push),
    .in_ready  (f_ready),
    .in_data   (rx_ff),
    .out_valid (data_valid),
    .out_ready (data_ready),
    .out_data  (data_out)
  );

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sda_s_ff <= 2'h3;
      scl_ff   <= 1'b1;
    end else begin
      sda_s_ff <= {sda_s_ff[0], bus.sda};
      scl_ff   <= idle | ph_ff[1];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_ff  <= eeprom_pkg::CTL_IDLE;
      qtr_ff    <= 6'h00;
      ph_ff     <= 2'h0;
      cnt_ff    <= 4'h0;
      byte_ff   <= 8'h00;
      rx_ff     <= 8'h00;
      stage_ff  <= 2'h0;
      rem_ff    <= 8'h00;
      addr_ff   <= '0;
      low_ff    <= 1'b0;
      ackbit_ff <= 1'b1;
      nack_ff   <= 1'b0;
      done_ff   <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      qtr_ff  <= (idle | tick) ? 6'h00 : qtr_ff + 6'h01;
      if (go) begin
        ph_ff <= ph_ff + 2'h1;
      end
      if (sample & in_send & ack_cell) begin
        ackbit_ff <= sda_in;
      end
      if (sample & in_recv & ~ack_cell) begin
        rx_ff <= {rx_ff[6:0], sda_in};
      end
      case (state_ff)
        eeprom_pkg::CTL_IDLE: begin
          ph_ff <= 2'h0;
          if (cmd_valid) begin
            state_ff <= eeprom_pkg::CTL_START;
            stage_ff <= cmd_random ? 2'h0 : 2'h2;
            addr_ff  <= cmd_addr;
            rem_ff   <= cmd_len;
            nack_ff  <= 1'b0;
          end
        end
        eeprom_pkg::CTL_START: begin
          if (drive_pt) begin
            low_ff <= 1'b0;
          end
          if (sample) begin
            low_ff <= 1'b1;
          end
          if (cell_end) begin
            state_ff <= eeprom_pkg::CTL_SEND;
            cnt_ff   <= 4'h0;
            byte_ff  <= {eeprom_pkg::DEV_TYPE, addr_ff[eeprom_pkg::ADDR_W-1:8],
                         stage_ff[1]};
          end
        end
        eeprom_pkg::CTL_SEND: begin
          if (drive_pt) begin
            low_ff <= ~ack_cell & ~byte_ff[7];
          end
          if (cell_end & ~ack_cell) begin
            cnt_ff  <= cnt_ff + 4'h1;
            byte_ff <= {byte_ff[6:0], 1'b0};
          end else if (cell_end & ackbit_ff) begin
            nack_ff  <= 1'b1;
            state_ff <= eeprom_pkg::CTL_STOP;
          end else if (cell_end) begin
            cnt_ff <= 4'h0;
            case (stage_ff)
              2'h0: begin
                stage_ff <= 2'h1;
                byte_ff  <= addr_ff[7:0];
              end
              2'h1: begin
                stage_ff <= 2'h2;
                state_ff <= eeprom_pkg::CTL_START;
              end
              default: begin
                state_ff <= eeprom_pkg::CTL_RECV;
              end
            endcase
          end
        end
        eeprom_pkg::CTL_RECV: begin
          if (drive_pt) begin
            low_ff <= ack_cell & more;
          end
          if (cell_end & ~ack_cell) begin
            cnt_ff <= cnt_ff + 4'h1;
          end else if (cell_end & more) begin
            cnt_ff <= 4'h0;
            rem_ff <= rem_ff - 8'h01;
          end else if (cell_end) begin
            state_ff <= eeprom_pkg::CTL_STOP;
          end
        end
        eeprom_pkg::CTL_STOP: begin
          if (drive_pt) begin
            low_ff <= 1'b1;
          end
          if (sample) begin
            low_ff <= 1'b0;
          end
          if (cell_end) begin
            state_ff <= eeprom_pkg::CTL_IDLE;
            done_ff  <= 1'b1;
          end
        end
        default: begin
          state_ff <= eeprom_pkg::CTL_IDLE;
        end
      endcase
    end
  end

  assign bus.scl        = scl_ff;
  assign bus.ctl_sda_o  = 1'b0;
  assign bus.ctl_sda_oe = low_ff;
  assign cmd_ready      = idle;
  assign done           = done_ff;
  assign nack           = nack_ff;
endmodule
`default_nettype wire

// ===== test/two_wire_sva.sv
// Purpose: wire checks on the joined two-wire link
// Assumes: one controller and one target on the link
// Notes:   bit counts restart at every start
`timescale 1ns/10ps
`default_nettype none
module two_wire_sva (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic scl,
  input wire logic sda,
  input wire logic ctl_sda_o,
  input wire logic ctl_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe
);
  logic       scl_q, sda_q, frm_ff, rd_ff;
  logic [7:0] rise_ff, hi_ff;
  wire        dev_lo = dev_sda_oe & ~dev_sda_o;
  wire        ctl_lo = ctl_sda_oe & ~ctl_sda_o;
  wire        rise   = scl & ~scl_q;
  wire        start  = scl & scl_q & sda_q & ~sda;
  wire        stop   = scl & scl_q & ~sda_q & sda;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk) begin
    scl_q <= scl;
    sda_q <= sda;
    hi_ff <= (!scl) ? 8'h00 : hi_ff + {7'h00, hi_ff != 8'hff};
  end
  always_ff @(posedge ref_clk) begin
    if (reset || start || stop)
      rise_ff <= 8'h00;
    else if (rise && rise_ff != 8'hff)
      rise_ff <= rise_ff + 8'h01;
  end
  // frame flag keeps a mid-frame reset from faking bit positions
  always_ff @(posedge ref_clk) begin
    frm_ff <= !reset && (start || (frm_ff && !stop));
    rd_ff  <= (reset || start) ? 1'b0 : (rise && rise_ff == 8'h07) ? sda : rd_ff;
  end
  ////////////////////////////////////////////////////////////////////////////
  AST_ADDR_ACK: assert property (frm_ff && rise && rise_ff == 8'h08 |-> !sda)
    else $error("address byte not acknowledged");
  AST_READ_OWN: assert property (frm_ff && rd_ff && rise
    && rise_ff inside {[8'h09:8'h10]} |-> !ctl_lo) else $error("controller drove read data");
  AST_ACK_FREE: assert property (frm_ff && rd_ff && rise && rise_ff == 8'h11 |-> !dev_lo)
    else $error("target held the controller ack slot");
  AST_NO_FIGHT: assert property (scl |-> !(dev_lo && ctl_lo))
    else $error("both ends pull sda with scl high");
  AST_DEV_HOLD: assert property (scl && scl_q && frm_ff |-> $stable(dev_lo))
    else $error("target moved sda with scl high");
  AST_STOP_REL: assert property (stop |-> !dev_lo [*8])
    else $error("target drives after stop");
  AST_IDLE_REL: assert property (hi_ff > 8'hc8 |-> !dev_lo)
    else $error("target drives an idle link");
  AST_SCL_LOW: assert property ($fell(scl) |-> !scl [*8])
    else $error("scl low phase too short");
  cover property (start && rise_ff == 8'h12);
  cover property (stop && rd_ff);
  cover property (frm_ff && rd_ff && rise && rise_ff == 8'h11 && !sda);
endmodule
`default_nettype wire

// ===== test/serial_eeprom_read_ops_tb.sv
// Purpose: bench joining both ends of the two-wire read link
// Assumes: cmd_len counts bytes; memory content unknown at start
// Notes:   bytes are checked for agreement across reads of one address
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_count++; \
  $display("Error %0t: value mismatch", $time); end end
module serial_eeprom_read_ops_tb;
  logic                          ref_clk = 1'b0;
  logic                          reset = 1'b1;
  logic                          cmd_valid = 1'b0, cmd_random = 1'b0, data_ready = 1'b0;
  logic [eeprom_pkg::ADDR_W-1:0] cmd_addr = '0, ptr = '0;
  logic [7:0]                    cmd_len = 8'h01, data_out, rd_byte;
  logic                          cmd_ready, data_valid, done, nack, busy, rd_strobe;
  logic [7:0]                    mem [2048];
  bit                            known [2048];
  logic [7:0]                    sent [$], got [$];
  logic [31:0]                   seed = 32'hd0b8e6ef;
  int                            err_count = 0, checks = 0, hold = 0;
  two_wire_if bus ();
  eeprom_read_target #(.WR_CYCLES(100)) eeprom_read_target_i (.ref_clk, .reset,
    .bus(bus), .busy, .rd_byte, .rd_strobe);
  eeprom_bus_controller eeprom_bus_controller_i (.ref_clk, .reset, .bus(bus), .cmd_valid,
    .cmd_ready, .cmd_random, .cmd_addr, .cmd_len, .data_valid, .data_ready, .data_out,
    .done, .nack);
  two_wire_sva two_wire_sva_i (.ref_clk, .reset, .scl(bus.scl), .sda(bus.sda),
    .ctl_sda_o(bus.ctl_sda_o), .ctl_sda_oe(bus.ctl_sda_oe),
    .dev_sda_o(bus.dev_sda_o), .dev_sda_oe(bus.dev_sda_oe));
  always #5 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  always @(posedge ref_clk) begin
    if (rd_strobe === 1'b1)
      sent.push_back(rd_byte);
    if (data_valid === 1'b1 && data_ready === 1'b1)
      got.push_back(data_out);
    data_ready <= (hold != 0) ? 1'b0 : 1'(xs());
  end
  task automatic complete_run();
    if (err_count == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // a current read takes the bench's own copy of the counter as its start
  task automatic rd(input logic rnd, input logic [10:0] a, input logic [7:0] n);
    logic [10:0] p;
    @(posedge ref_clk);
    cmd_valid  <= 1'b1;
    cmd_random <= rnd;
    cmd_addr   <= a;
    cmd_len    <= n;
    do @(posedge ref_clk); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    do @(posedge ref_clk); while (done !== 1'b1);
    while (got.size() < n) @(posedge ref_clk);
    p = rnd ? a : ptr;
    `CHK(nack, 1'b0)
    `CHK(busy, 1'b0)
    `CHK(sent.size(), int'(n))
    for (int i = 0; i < n; i++) begin
      `CHK(got[i], sent[i])
      if (known[p])
        `CHK(got[i], mem[p])
      else begin
        mem[p] = got[i];
        known[p] = 1'b1;
      end
      p = p + 11'h001;
    end
    ptr = p;
    sent.delete();
    got.delete();
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #800000;
    err_count++;
    complete_run();
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    rd(1'b1, 11'h002, 8'h01);
    rd(1'b1, 11'h000, 8'h02);
    rd(1'b1, 11'h7fe, 8'h04);
    rd(1'b0, 11'h000, 8'h01);
    reset <= 1'b1;
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    rd(1'b0, 11'h000, 8'h02);
    hold = 1;
    fork
      rd(1'b1, 11'h7ff, 8'h06);
      begin
        repeat (8000) @(posedge ref_clk);
        `CHK(bus.scl, 1'b0)
        hold = 0;
      end
    join
    repeat (6) rd(1'(xs()), 11'(xs()), 8'(xs() % 3 + 1));
    complete_run();
  end
endmodule
`default_nettype wire
